/* File: tme_asserts.sv */
// Checker: bus answer, enable views, interrupt and byte events of tme_top
`timescale 1ns/1ps
`default_nettype none
module tme_asserts
  import tme_pkg::*;
(
  input wire logic        REF_CLK_I,
  input wire logic        RESET_I,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [11:0] WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        TX_BYTE_START_I,
  input wire logic        TX_BYTE_LAST_I,
  input wire logic        RX_BYTE_START_I,
  input wire logic        RX_BYTE_LAST_I,
  input wire logic        FINAL_TX_BYTE_EVENT_O,
  input wire logic        FINAL_RX_BYTE_EVENT_O,
  input wire logic [6:0]  EVENT_FLAGS_I,
  input wire logic [6:0]  ENABLE_O,
  input wire logic        IRQ_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I);

  function automatic logic [6:0] pick(input logic [31:0] w);
    return {w[TME_BIT_FINAL_TX], w[TME_BIT_FINAL_RX], w[TME_BIT_TX_BEGAN],
            w[TME_BIT_RX_BEGAN], w[TME_BIT_SUSPENDED], w[TME_BIT_ERROR],
            w[TME_BIT_STOPPED]};
  endfunction : pick

  // Partial byte selects are left out: their lane merge is not modelled
  logic wr_ack;
  assign wr_ack = WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I &&
                  WB_SEL_I == 4'hf;

  // ******************************************************
  // Assertions
  // ******************************************************
  AST_ACK_NEXT: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("request not answered in the next cycle");
  AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("acknowledge longer than one cycle");
  AST_MASK_WR: assert property (
    wr_ack && WB_ADR_I == TME_OFS_MASK |-> ##2
    ENABLE_O == pick($past(WB_DAT_I, 2)))
    else $error("mask write did not replace the enables");
  AST_SET_WR: assert property (
    wr_ack && WB_ADR_I == TME_OFS_SET |-> ##2
    ENABLE_O == ($past(ENABLE_O) | pick($past(WB_DAT_I, 2))))
    else $error("set write did not only add enables");
  AST_CLR_WR: assert property (
    wr_ack && WB_ADR_I == TME_OFS_CLEAR |-> ##2
    ENABLE_O == ($past(ENABLE_O) & ~pick($past(WB_DAT_I, 2))))
    else $error("clear write did not only remove enables");
  AST_RD_STATE: assert property (
    WB_ACK_O && !WB_WE_I && (WB_ADR_I == TME_OFS_SET ||
    WB_ADR_I == TME_OFS_MASK) |-> pick(WB_DAT_O) == ENABLE_O &&
    (WB_DAT_O & ~TME_EN_IMPL) == 32'h0000_0000)
    else $error("read data differs from the enable state");
  AST_FTX_CAUSE: assert property (
    FINAL_TX_BYTE_EVENT_O |-> $past(TX_BYTE_START_I && TX_BYTE_LAST_I))
    else $error("final transmit event without a last byte start");
  AST_FTX_FIRE: assert property (
    TX_BYTE_START_I && TX_BYTE_LAST_I |=> FINAL_TX_BYTE_EVENT_O)
    else $error("final transmit event missing");
  AST_FRX_FIRE: assert property (
    RX_BYTE_START_I && RX_BYTE_LAST_I |=> FINAL_RX_BYTE_EVENT_O)
    else $error("final receive event missing");
  AST_IRQ: assert property (
    IRQ_O == |($past(EVENT_FLAGS_I) & ENABLE_O))
    else $error("interrupt does not follow flags and enables");

  cover property (wr_ack && WB_ADR_I == TME_OFS_SET);
  cover property ($rose(IRQ_O));
  cover property (FINAL_TX_BYTE_EVENT_O);
endmodule : tme_asserts

bind tme_top tme_asserts u_asserts (.REF_CLK_I(REF_CLK_I),
  .RESET_I(RESET_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .TX_BYTE_START_I(TX_BYTE_START_I), .TX_BYTE_LAST_I(TX_BYTE_LAST_I),
  .RX_BYTE_START_I(RX_BYTE_START_I), .RX_BYTE_LAST_I(RX_BYTE_LAST_I),
  .FINAL_TX_BYTE_EVENT_O(FINAL_TX_BYTE_EVENT_O),
  .FINAL_RX_BYTE_EVENT_O(FINAL_RX_BYTE_EVENT_O),
  .EVENT_FLAGS_I(EVENT_FLAGS_I), .ENABLE_O(ENABLE_O), .IRQ_O(IRQ_O));
`default_nettype wire

/* File: tme_en_if.sv */
// Interface: enable-state update strobes between decoder and store
`timescale 1ns/1ps
`default_nettype none
interface tme_en_if;
  logic        wr_en;
  logic [31:0] wr_bits;
  logic [31:0] wr_mask;
  logic        set_en;
  logic [31:0] set_bits;
  logic        clr_en;
  logic [31:0] clr_bits;
  logic [31:0] enable;

  modport ctl   (output wr_en, wr_bits, wr_mask, set_en, set_bits,
                 clr_en, clr_bits, input enable);
  modport store (input wr_en, wr_bits, wr_mask, set_en, set_bits,
                 clr_en, clr_bits, output enable);
endinterface : tme_en_if
`default_nettype wire

/* File: tme_en_store.sv */
// Module: the single enable state behind the mask, set and clear views
`timescale 1ns/1ps
`default_nettype none
module tme_en_store
  import tme_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  tme_en_if.store   en_if
);

  logic [31:0] en_r;
  logic [31:0] en_nxt;

  // ****************************************************************
  // Update
  // ****************************************************************
  always_comb begin
    en_nxt = en_r;
    if (en_if.wr_en) begin
      en_nxt = (en_r & ~en_if.wr_mask) | (en_if.wr_bits & en_if.wr_mask);
    end
    if (en_if.set_en) begin
      en_nxt = en_nxt | en_if.set_bits;
    end
    if (en_if.clr_en) begin
      en_nxt = en_nxt & ~en_if.clr_bits;
    end
    // Unimplemented positions never hold a one
    en_nxt = en_nxt & TME_EN_IMPL;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_r <= TME_EN_RESET;
    end else begin
      en_r <= en_nxt;
    end
  end

  assign en_if.enable = en_r;

endmodule : tme_en_store
`default_nettype wire

/* File: tme_pkg.sv */
// Package: register map, field positions and reset values
package tme_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] TME_OFS_MASK  = 12'h0300;
  localparam logic [11:0] TME_OFS_SET   = 12'h0304;
  localparam logic [11:0] TME_OFS_CLEAR = 12'h0308;

  // ****************************************************************
  // Enable bit positions
  // ****************************************************************
  localparam int TME_BIT_STOPPED   = 1;
  localparam int TME_BIT_ERROR     = 9;
  localparam int TME_BIT_SUSPENDED = 18;
  localparam int TME_BIT_RX_BEGAN  = 19;
  localparam int TME_BIT_TX_BEGAN  = 20;
  localparam int TME_BIT_FINAL_RX  = 23;
  localparam int TME_BIT_FINAL_TX  = 24;

  localparam int TME_NUM_EVENTS = 7;

  // ****************************************************************
  // Reset values and masks
  // ****************************************************************
  localparam logic [31:0] TME_EN_RESET = 32'h0000_0000;
  localparam logic [31:0] TME_EN_IMPL  = 32'h0000_0000
    | (32'h0000_0001 << TME_BIT_STOPPED)
    | (32'h0000_0001 << TME_BIT_ERROR)
    | (32'h0000_0001 << TME_BIT_SUSPENDED)
    | (32'h0000_0001 << TME_BIT_RX_BEGAN)
    | (32'h0000_0001 << TME_BIT_TX_BEGAN)
    | (32'h0000_0001 << TME_BIT_FINAL_RX)
    | (32'h0000_0001 << TME_BIT_FINAL_TX);
  localparam logic [31:0] TME_RDATA_UNMAPPED = 32'h0000_0000;

  // Event index order on the 7-bit event vectors
  typedef enum logic [2:0] {
    TME_EV_STOPPED,
    TME_EV_ERROR,
    TME_EV_SUSPENDED,
    TME_EV_RX_BEGAN,
    TME_EV_TX_BEGAN,
    TME_EV_FINAL_RX,
    TME_EV_FINAL_TX
  } tme_event_e;

  // Place a packed event vector at the enable bit positions
  function automatic logic [31:0] tme_spread(
    input logic [TME_NUM_EVENTS-1:0] ev
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    w[TME_BIT_STOPPED]   = ev[TME_EV_STOPPED];
    w[TME_BIT_ERROR]     = ev[TME_EV_ERROR];
    w[TME_BIT_SUSPENDED] = ev[TME_EV_SUSPENDED];
    w[TME_BIT_RX_BEGAN]  = ev[TME_EV_RX_BEGAN];
    w[TME_BIT_TX_BEGAN]  = ev[TME_EV_TX_BEGAN];
    w[TME_BIT_FINAL_RX]  = ev[TME_EV_FINAL_RX];
    w[TME_BIT_FINAL_TX]  = ev[TME_EV_FINAL_TX];
    return w;
  endfunction : tme_spread

  // Expand Wishbone byte selects to a bit mask
  function automatic logic [31:0] tme_lanes(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : tme_lanes

endpackage : tme_pkg

/* File: tme_tb_top.sv */
// Testbench: register views, interrupt gating and byte events of tme_top
`timescale 1ns/1ps
`default_nettype none
module tme_tb_top
  import tme_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] zero = 32'h0000_0000;
  logic [1:0]  txb = 2'h0;
  logic [1:0]  rxb = 2'h0;
  logic [6:0]  flags = 7'h00;
  logic [6:0]  exp_en, en_o;
  logic [31:0] rdat;
  logic        ack, irq, ftx, frx;
  int          bad_count = 0;
  int          checks_done = 0;
  int          pos[7] = '{TME_BIT_STOPPED, TME_BIT_ERROR, TME_BIT_SUSPENDED,
    TME_BIT_RX_BEGAN, TME_BIT_TX_BEGAN, TME_BIT_FINAL_RX, TME_BIT_FINAL_TX};

  // Lanes for the next access; a whole word unless a scenario narrows it
  logic [3:0]  bsel = 4'hf;
  logic [3:0]  sel = 4'hf;
  tme_top u_dut (.REF_CLK_I(clk), .RESET_I(rst), .WB_CYC_I(req),
    .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .TX_BYTE_START_I(txb[1]), .TX_BYTE_LAST_I(txb[0]),
    .RX_BYTE_START_I(rxb[1]), .RX_BYTE_LAST_I(rxb[0]),
    .FINAL_TX_BYTE_EVENT_O(ftx), .FINAL_RX_BYTE_EVENT_O(frx),
    .EVENT_FLAGS_I(flags), .ENABLE_O(en_o), .IRQ_O(irq));

  function automatic logic [31:0] spr(input logic [6:0] e);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int k = 0; k < 7; k++) w[pos[k]] = e[k];
    return w;
  endfunction : spr

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  // One classic cycle; a read compares its data with e
  task automatic wb(input logic [11:0] a, input logic w,
                    input logic [31:0] d, input logic [31:0] e);
    int n = 0;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= bsel;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    req <= 1'b0;
    if (ack !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
    if (!w) check("read data", rdat, e);
  endtask : wb

  initial begin
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wb(TME_OFS_MASK, 1'b0, zero, TME_EN_RESET);
    wb(TME_OFS_SET, 1'b0, zero, TME_EN_RESET);
    $display("test reset values done");
    for (int k = 0; k < 7; k++) begin
      exp_en = 7'h01 << k;
      // Unused positions written as ones must still read zero
      wb(TME_OFS_MASK, 1'b1, spr(exp_en) | ~TME_EN_IMPL, zero);
      wb(TME_OFS_MASK, 1'b0, zero, spr(exp_en));
      wb(TME_OFS_SET, 1'b0, zero, spr(exp_en));
    end
    wb(TME_OFS_MASK, 1'b1, zero, zero);
    // The state is empty again, so the expectation must restart too
    exp_en = 7'h00;
    $display("test mask done");
    for (int k = 0; k < 7; k++) begin
      exp_en[k] = 1'b1;
      wb(TME_OFS_SET, 1'b1, spr(7'h01 << k), zero);
      wb(TME_OFS_SET, 1'b0, zero, spr(exp_en));
    end
    wb(TME_OFS_SET, 1'b1, zero, zero);
    wb(TME_OFS_MASK, 1'b0, zero, spr(exp_en));
    check("enable out", 32'(en_o), 32'(exp_en));
    $display("test set done");
    for (int k = 0; k < 7; k++) begin
      flags <= 7'h01 << k;
      repeat (3) @(posedge clk);
      check("irq on", 32'(irq), 32'h0000_0001);
      exp_en[k] = 1'b0;
      wb(TME_OFS_CLEAR, 1'b1, spr(7'h01 << k), zero);
      wb(TME_OFS_SET, 1'b0, zero, spr(exp_en));
      check("irq off", 32'(irq), zero);
    end
    flags <= 7'h00;
    $display("test clear and irq done");
    wb(12'h30c, 1'b1, ~zero, zero);
    wb(12'h30c, 1'b0, zero, zero);
    wb(TME_OFS_MASK, 1'b0, zero, zero);
    $display("test unmapped done");
    // Only the selected lanes may change, in all three views
    bsel = 4'h4;
    wb(TME_OFS_MASK, 1'b1, ~zero, zero);
    wb(TME_OFS_MASK, 1'b0, zero, spr(7'h3c));
    bsel = 4'h9;
    wb(TME_OFS_SET, 1'b1, ~zero, zero);
    bsel = 4'h4;
    wb(TME_OFS_CLEAR, 1'b1, ~zero, zero);
    bsel = 4'hf;
    wb(TME_OFS_CLEAR, 1'b0, zero, spr(7'h41));
    wb(TME_OFS_MASK, 1'b1, zero, zero);
    wb(TME_OFS_SET, 1'b0, zero, zero);
    $display("test byte lanes done");
    for (int j = 0; j < 2; j++) begin
      txb <= {1'b1, j == 0};
      rxb <= {1'b1, j == 1};
      @(posedge clk);
      txb <= 2'h0;
      rxb <= 2'h0;
      @(posedge clk);
      check("final tx", 32'(ftx), 32'(j == 0));
      check("final rx", 32'(frx), 32'(j == 1));
      @(posedge clk);
      check("event pulse", 32'({ftx, frx}), zero);
    end
    $display("test byte events done");
    report_and_stop();
  end
endmodule : tme_tb_top
`default_nettype wire

/* File: tme_top.sv */
// Module: interrupt enable registers of the two-wire master, Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module tme_top
  import tme_pkg::*;
(
  input  wire logic                      REF_CLK_I,
  input  wire logic                      RESET_I,
  // Wishbone classic slave
  input  wire logic                      WB_CYC_I,
  input  wire logic                      WB_STB_I,
  input  wire logic                      WB_WE_I,
  input  wire logic [11:0]               WB_ADR_I,
  input  wire logic [3:0]                WB_SEL_I,
  input  wire logic [31:0]               WB_DAT_I,
  output var  logic [31:0]               WB_DAT_O,
  output var  logic                      WB_ACK_O,
  // Byte engine boundary indications, same clock
  input  wire logic                      TX_BYTE_START_I,
  input  wire logic                      TX_BYTE_LAST_I,
  input  wire logic                      RX_BYTE_START_I,
  input  wire logic                      RX_BYTE_LAST_I,
  output var  logic                      FINAL_TX_BYTE_EVENT_O,
  output var  logic                      FINAL_RX_BYTE_EVENT_O,
  // Pending event flags from the event registers, same clock
  input  wire logic [TME_NUM_EVENTS-1:0] EVENT_FLAGS_I,
  output var  logic [TME_NUM_EVENTS-1:0] ENABLE_O,
  output var  logic                      IRQ_O
);

  tme_en_if en_if ();

  logic        req;
  logic        hit_mask;
  logic        hit_set;
  logic        hit_clear;
  logic        commit;
  logic [31:0] lanes;
  logic [31:0] rdata_nxt;
  logic [31:0] pend_w;
  logic        ack_r;
  logic [31:0] rdata_r;
  logic        irq_r;
  logic        ftx_r;
  logic        frx_r;
  logic [TME_NUM_EVENTS-1:0] enable_r;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Answer one cycle after the request; the write lands on the same
  // edge at which the master samples ack, so nothing changes early.
  assign req       = WB_CYC_I & WB_STB_I;
  assign commit    = req & ack_r & WB_WE_I;
  assign hit_mask  = (WB_ADR_I == TME_OFS_MASK);
  assign hit_set   = (WB_ADR_I == TME_OFS_SET);
  assign hit_clear = (WB_ADR_I == TME_OFS_CLEAR);
  assign lanes     = tme_lanes(WB_SEL_I);

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // ****************************************************************
  // Enable state updates
  // ****************************************************************
  assign en_if.wr_en    = commit & hit_mask;
  assign en_if.wr_bits  = WB_DAT_I;
  assign en_if.wr_mask  = lanes;
  assign en_if.set_en   = commit & hit_set;
  // Zeros in the set value are ignored by the or-in
  assign en_if.set_bits = WB_DAT_I & lanes;
  assign en_if.clr_en   = commit & hit_clear;
  assign en_if.clr_bits = WB_DAT_I & lanes;

  tme_en_store u_store (
    .clk_i (REF_CLK_I),
    .rst_i (RESET_I),
    .en_if (en_if.store)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************
  // All three views read back the one shared enable state
  always_comb begin
    rdata_nxt = TME_RDATA_UNMAPPED;
    if (hit_mask || hit_set || hit_clear) begin
      rdata_nxt = en_if.enable & TME_EN_IMPL;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      rdata_r <= 32'h0000_0000;
    end else if (req && !ack_r) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign WB_DAT_O = rdata_r;
  assign WB_ACK_O = ack_r;

  // ****************************************************************
  // Final byte events
  // ****************************************************************
  // A one-cycle pulse in the cycle after the boundary where the last byte begins
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      ftx_r <= 1'b0;
      frx_r <= 1'b0;
    end else begin
      ftx_r <= TX_BYTE_START_I & TX_BYTE_LAST_I;
      frx_r <= RX_BYTE_START_I & RX_BYTE_LAST_I;
    end
  end

  assign FINAL_TX_BYTE_EVENT_O = ftx_r;
  assign FINAL_RX_BYTE_EVENT_O = frx_r;

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  // Each event is gated by its own enable position
  assign pend_w = tme_spread(EVENT_FLAGS_I) & en_if.enable;

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |pend_w;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      enable_r <= '0;
    end else begin
      enable_r <= {en_if.enable[TME_BIT_FINAL_TX],
                   en_if.enable[TME_BIT_FINAL_RX],
                   en_if.enable[TME_BIT_TX_BEGAN],
                   en_if.enable[TME_BIT_RX_BEGAN],
                   en_if.enable[TME_BIT_SUSPENDED],
                   en_if.enable[TME_BIT_ERROR],
                   en_if.enable[TME_BIT_STOPPED]};
    end
  end

  assign IRQ_O    = irq_r;
  assign ENABLE_O = enable_r;

endmodule : tme_top
`default_nettype wire
